// ===== srmc_pkg.sv
package srmc_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_PERIOD_NS = 10;

  // speed grade chosen at build time: 0 = fastest, 1 = middle, 2 = slowest
  localparam int GRADE = 1;

  // minimum times in ns, one entry per grade (fast, middle, slow)
  localparam real T_ADDRESS_ACCESS_DELAY[3]       = '{8.0, 10.0, 20.0};
  localparam real T_OE_ACCESS[3]                  = '{5.5, 6.0, 8.0};
  localparam real T_OE_HIGHZ[3]                   = '{4.0, 5.0, 8.0};
  localparam real T_WRITE_CYCLE[3]                = '{8.0, 10.0, 20.0};
  localparam real T_WRITE_PULSE[3]                = '{6.5, 8.0, 12.0};
  localparam real T_WRITE_PULSE_OUTPUTS_ON[3]     = '{8.0, 10.0, 17.0};
  localparam real T_WRITE_DATA_SETUP[3]           = '{5.0, 6.0, 9.0};
  localparam real T_WRITE_START_OUTPUT_OFF[3]     = '{3.5, 4.0, 9.0};
  localparam real T_WRITE_END_OUTPUT_ON_DELAY[3]  = '{2.0, 2.0, 3.0};

  function automatic int cyc_up(real ns);
    int c;
    c = int'($ceil(ns / CLK_PERIOD_NS));
    return (c < 1) ? 1 : c;
  endfunction

  // read: access wait covers address, chip select, output enable and byte lane paths
  localparam int RD_ACCESS_CYC = cyc_up(T_ADDRESS_ACCESS_DELAY[GRADE]);
  localparam int RD_RELEASE_CYC = cyc_up(T_OE_HIGHZ[GRADE]);
  // write strobe low time; output enable held high so the plain pulse applies
  localparam int WR_PULSE_CYC = cyc_up(T_WRITE_PULSE[GRADE] > T_WRITE_DATA_SETUP[GRADE]
                                       ? T_WRITE_PULSE[GRADE] : T_WRITE_DATA_SETUP[GRADE]);
  localparam int WR_DRIVE_DLY_CYC = cyc_up(T_WRITE_START_OUTPUT_OFF[GRADE]);
  localparam int WR_CYCLE_CYC = cyc_up(T_WRITE_CYCLE[GRADE]);
  localparam int WR_RECOVER_CYC = cyc_up(T_WRITE_END_OUTPUT_ON_DELAY[GRADE]);
  localparam int CNT_W = 4;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              upper_en;
    logic              lower_en;
  } srmc_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] rdata;
    logic              single_error_corrected_flag;
    logic              double_error_detected_flag;
  } srmc_rsp_t;

  typedef struct packed {
    logic              chip_select_n;
    logic              output_enable_n;
    logic              write_enable_n;
    logic              upper_byte_enable_n;
    logic              lower_byte_enable_n;
    logic [ADDR_W-1:0] addr;
  } srmc_pins_t;

endpackage

// ===== srmc_host.sv
// Summary of operation
// R1: write happens only while chip select, a byte enable and write enable all low.
// R2: write ends when any strobe rises; we end it by raising write enable.
// R3: write data is stable setup time before write enable rises, held after.
// R4: with output enable low the write pulse must exceed turn-off plus setup.
// R5: after write starts with output enable low, do not drive data meanwhile.
// R6: device may still drive old read data if output enable low at write.
// R7: error flags are sampled as read data, together with the data word.
// R8: new read data valid within access time of address change.
// R9: address is valid before or with chip select falling in a read.
// R10: output enable access and release times are waited out.
// R11: byte lane access and release times are waited out.
// R12: write cycle, address, select and byte enable lead write end enough.
// R13: address set up before write start and held after write end.
// R14: device does not drive outputs right after write enable rises.
// R15: output enable stays high through every write cycle.
// R16: upper byte enable gates bits 15:8, lower gates bits 7:0.
module srmc_host
  import srmc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire srmc_req_t         req,
  output logic                   req_ready,
  output srmc_rsp_t              rsp,
  output srmc_pins_t             pins,
  output logic [DATA_W-1:0]      data_out,
  output logic [DATA_W-1:0]      data_oe,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              single_error_corrected_flag,
  input  wire logic              double_error_detected_flag
);

  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_RD_REL, ST_WR_SETUP, ST_WR_PULSE,
                            ST_WR_END, ST_WR_REC} srmc_state_t;

  srmc_state_t          state_r, state_nxt;
  logic [CNT_W-1:0]     cnt_r, cnt_nxt;
  logic                 ready_r, ready_nxt;
  srmc_rsp_t            rsp_r, rsp_nxt;
  srmc_pins_t           pins_r, pins_nxt;
  logic [DATA_W-1:0]    dout_r, dout_nxt;
  logic [DATA_W-1:0]    doe_r, doe_nxt;

  localparam srmc_pins_t PINS_IDLE = '{chip_select_n: 1'b1, output_enable_n: 1'b1,
                                       write_enable_n: 1'b1, upper_byte_enable_n: 1'b1,
                                       lower_byte_enable_n: 1'b1, addr: '0};

  function automatic logic [DATA_W-1:0] lane_mask(input logic up, input logic lo);
    lane_mask = {{BYTE_W{up}}, {BYTE_W{lo}}}; // R16
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ready_nxt = ready_r;
    rsp_nxt   = rsp_r;
    pins_nxt  = pins_r;
    dout_nxt  = dout_r;
    doe_nxt   = doe_r;
    rsp_nxt.valid = 1'b0;
    if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
    case (state_r)
      ST_IDLE:
      begin
        if (req.valid && ready_r)
        begin
          ready_nxt = 1'b0;
          // address and select move together: address valid no later than select
          pins_nxt.addr                = req.addr; // R9 R13
          pins_nxt.chip_select_n       = 1'b0;
          pins_nxt.upper_byte_enable_n = ~req.upper_en; // R16
          pins_nxt.lower_byte_enable_n = ~req.lower_en; // R16
          if (req.write)
          begin
            pins_nxt.output_enable_n = 1'b1; // R15
            dout_nxt  = req.wdata;
            cnt_nxt   = CNT_W'(WR_DRIVE_DLY_CYC);
            state_nxt = ST_WR_SETUP;
          end
          else
          begin
            pins_nxt.output_enable_n = 1'b0;
            cnt_nxt   = CNT_W'(RD_ACCESS_CYC); // R8 R10 R11
            state_nxt = ST_RD;
          end
        end
      end
      ST_RD:
      begin
        if (cnt_r == '0)
        begin
          rsp_nxt.valid = 1'b1;
          rsp_nxt.rdata = data_in & lane_mask(~pins_r.upper_byte_enable_n,
                                              ~pins_r.lower_byte_enable_n); // R16
          rsp_nxt.single_error_corrected_flag = single_error_corrected_flag; // R7
          rsp_nxt.double_error_detected_flag  = double_error_detected_flag; // R7
          pins_nxt  = PINS_IDLE;
          pins_nxt.addr = pins_r.addr;
          cnt_nxt   = CNT_W'(RD_RELEASE_CYC); // R10 R11
          state_nxt = ST_RD_REL;
        end
      end
      ST_RD_REL:
      begin
        // the bus must float before a following write may drive it
        if (cnt_r == '0)
        begin
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_WR_SETUP:
      begin
        // strobes settle and any leftover read drive dies before data goes out
        if (cnt_r == '0)
        begin
          pins_nxt.write_enable_n = 1'b0; // R1
          cnt_nxt   = CNT_W'(WR_PULSE_CYC); // R4 R12
          state_nxt = ST_WR_PULSE;
        end
      end
      ST_WR_PULSE:
      begin
        doe_nxt = lane_mask(~pins_r.upper_byte_enable_n,
                            ~pins_r.lower_byte_enable_n); // R5 R6
        if (cnt_r == '0 && doe_r != '0)
        begin
          // data stood at least one full pulse count before this edge
          pins_nxt.write_enable_n = 1'b1; // R2 R3
          cnt_nxt   = CNT_W'(WR_CYCLE_CYC);
          state_nxt = ST_WR_END;
        end
      end
      ST_WR_END:
      begin
        // data, address and selects held one more cycle after write end
        pins_nxt  = PINS_IDLE; // R3 R13
        pins_nxt.addr = pins_r.addr;
        doe_nxt   = '0;
        cnt_nxt   = CNT_W'(WR_RECOVER_CYC); // R14
        state_nxt = ST_WR_REC;
      end
      ST_WR_REC:
      begin
        if (cnt_r == '0)
        begin
          ready_nxt = 1'b1; // R12
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
        pins_nxt  = PINS_IDLE;
        doe_nxt   = '0;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      ready_r <= 1'b1;
      rsp_r   <= '0;
      pins_r  <= PINS_IDLE;
      dout_r  <= '0;
      doe_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ready_r <= ready_nxt;
      rsp_r   <= rsp_nxt;
      pins_r  <= pins_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
    end
  end

  assign req_ready = ready_r;
  assign rsp       = rsp_r;
  assign pins      = pins_r;
  assign data_out  = dout_r;
  assign data_oe   = doe_r;

endmodule

// ===== srmc_chk.sv
module srmc_chk
  import srmc_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire srmc_req_t         req,
  input wire logic              req_ready,
  input wire srmc_rsp_t         rsp,
  input wire srmc_pins_t        pins,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [DATA_W-1:0] data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire we = !pins.write_enable_n;
  wire dv = data_oe != 16'h0;
  property p_oe; we |-> pins.output_enable_n; endproperty
  a_oe: assert property (p_oe) else $error("oe low in write");
  property p_early; dv |-> $past(we); endproperty
  a_early: assert property (p_early) else $error("data driven early");
  property p_hold; we && dv |=> $stable(data_out) && dv; endproperty
  a_hold: assert property (p_hold) else $error("write data not held");
  property p_addr; !pins.chip_select_n |=> pins.chip_select_n || $stable(pins.addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_lane;
    dv |-> data_oe == {{8{!pins.upper_byte_enable_n}}, {8{!pins.lower_byte_enable_n}}};
  endproperty
  a_lane: assert property (p_lane) else $error("lane mismatch");
  property p_pulse; $fell(pins.write_enable_n) |-> !pins.chip_select_n ##1 we ##1 !we; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse width");
  property p_rd; req.valid && req_ready && !req.write |-> ##3 rsp.valid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_wr; req.valid && req_ready && req.write |=> !req_ready [*7] ##1 req_ready; endproperty
  a_wr: assert property (p_wr) else $error("write cycle length");
endmodule

bind srmc_host srmc_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_ready(req_ready),
  .rsp(rsp), .pins(pins), .data_out(data_out), .data_oe(data_oe));

// ===== srmc_mem.sv
module srmc_mem
  import srmc_pkg::*;
(
  input  wire srmc_pins_t        pins,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic [DATA_W-1:0] data_oe,
  input  wire logic [1:0]        err,
  output logic [DATA_W-1:0]      data_in,
  output logic                   sec,
  output logic                   ded
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] m [256];
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] junk = 16'h5a3c;
  // outputs linger for the turn-off delay after write enable falls and
  // come back only that long after it rises again
  wire we_dly;
  assign #4 we_dly = pins.write_enable_n;
  wire rd = !pins.chip_select_n && !pins.output_enable_n && we_dly;
  wire [DATA_W-1:0] ln = {{8{!pins.upper_byte_enable_n}}, {8{!pins.lower_byte_enable_n}}};
  wire [DATA_W-1:0] dr = rd ? ln : 16'h0;
  // released lanes toggle so a stale word can never pass as read data
  // slower than the flag delay so released flags really move
  always #7 junk = ~junk;
  assign #6 q = m[pins.addr[7:0]];
  assign data_in = (data_oe & data_out) | (~data_oe & ((dr & q) | (~dr & junk)));
  assign #6 sec = rd ? err[0] : junk[0];
  assign #6 ded = rd ? err[1] : junk[1];
  always @(posedge pins.write_enable_n)
    if (!pins.chip_select_n)
      m[pins.addr[7:0]] = (m[pins.addr[7:0]] & ~ln) | (data_in & ln);
endmodule

// ===== tb.sv
module tb
  import srmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk_sys = 1'b0;
  logic              nrst = 1'b0;
  srmc_req_t         req = '0;
  logic              req_ready;
  srmc_rsp_t         rsp;
  srmc_pins_t        pins;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] data_oe;
  logic [DATA_W-1:0] data_in;
  logic              sec;
  logic              ded;
  logic [1:0]        err = 2'b00;
  logic [DATA_W-1:0] sh [256];
  logic [19:0]       expq [$];
  logic [19:0]       nxt;
  logic [31:0]       rnd = 32'hc7a3;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  srmc_host uut (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_ready(req_ready), .rsp(rsp),
    .pins(pins), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .single_error_corrected_flag(sec), .double_error_detected_flag(ded));
  srmc_mem u_mem (.pins(pins), .data_out(data_out), .data_oe(data_oe), .err(err),
    .data_in(data_in), .sec(sec), .ded(ded));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // waits for ready at the falling edge, where it has settled
  task automatic op(input logic w, input logic [7:0] a, input logic [1:0] ln, input logic [1:0] e);
    logic [DATA_W-1:0] mk;
    mk = {{8{ln[1]}}, {8{ln[0]}}};
    for (int n = 0; req_ready !== 1'b1 && n < 20; n++)
      @(negedge clk_sys);
    rnd = lfsr(rnd);
    err <= e;
    req <= '{1'b1, w, {rnd[18:8], a}, rnd[31:16], ln[1], ln[0]};
    if (w)
      sh[a] = (sh[a] & ~mk) | (rnd[31:16] & mk);
    else
      expq.push_back({2'b00, sh[a] & mk, e[0], e[1]});
    @(negedge clk_sys);
    req.valid <= 1'b0;
  endtask
  always @(negedge clk_sys)
  begin
    if (rsp.valid === 1'b1)
    begin
      nxt = expq.size() > 0 ? expq.pop_front() : 20'hfffff;
      chk({2'b00, rsp[17:0]}, nxt);
    end
    if (pins.chip_select_n === 1'b0)
    begin
      chk({1'b0, pins.addr}, {1'b0, req.addr});
      chk({18'h0, pins.upper_byte_enable_n, pins.lower_byte_enable_n},
          {18'h0, ~req.upper_en, ~req.lower_en});
    end
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (16) @(negedge clk_sys);
    chk({req_ready, pins.chip_select_n, pins.write_enable_n, pins.output_enable_n, data_oe}, 20'hf0000);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
      op(1'b1, 8'(i), 2'b11, 2'b00);
    $display("test fill done");
    for (int i = 0; i < 40; i++)
    begin
      rnd = lfsr(rnd);
      op(rnd[0], {5'h0, rnd[3:1]}, rnd[5:4] == 2'b00 ? 2'b11 : rnd[5:4], rnd[7:6]);
    end
    repeat (8) @(negedge clk_sys);
    chk(20'(expq.size()), 20'h0);
    $display("test random mix done");
    nrst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({req_ready, pins.chip_select_n, pins.write_enable_n, pins.output_enable_n, data_oe}, 20'hf0000);
    nrst <= 1'b1;
    op(1'b0, 8'h0, 2'b11, 2'b11);
    repeat (8) @(negedge clk_sys);
    chk(20'(expq.size()), 20'h0);
    $display("test mid reset done");
    end_of_test();
  end
endmodule
